/* File: acsp_consts.svh */
// Constants of the external-clock serial port: word lengths, reset values
`ifndef ACSP_CONSTS_SVH
`define ACSP_CONSTS_SVH

// ----------------------------------------
// Word lengths
// ----------------------------------------
`define ACSP_LEN_LONG   5'h18
`define ACSP_LEN_SHORT  5'h10
`define ACSP_LEN_CTRL   5'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACSP_CTRL_RST   24'h000000
`define ACSP_CALIB_RST  24'h000000
`define ACSP_OUT_RST    24'h000000
`define ACSP_CNT_RST    5'h00

`endif

/* File: acsp_pkg.sv */
// Types shared by the serial port modules
package acsp_pkg;

  // ----------------------------------------
  // Data types
  // ----------------------------------------
  typedef logic [23:0] acsp_word_t;

  typedef struct packed {
    logic       valid;
    acsp_word_t data;
  } acsp_conv_s;

  typedef enum logic [0:0] {
    ACSP_NO_WORD,
    ACSP_WORD_PEND
  } acsp_rdy_e;

endpackage

/* File: acsp_sync.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module acsp_sync (
  input  wire logic clk_i,   // Destination clock
  input  wire logic d_i,     // Level from another domain
  output logic      q_o      // Synchronised level
);

  logic meta_r;

  // Second flop is the only reader of the first
  always_ff @(posedge clk_i) begin
    meta_r <= d_i;
    q_o    <= meta_r;
  end

endmodule

/* File: acsp_port.sv */
// External-clock serial port of the converter, register side and link side
`timescale 1ns/1ps
`include "acsp_consts.svh"
module acsp_port
  import acsp_pkg::*;
(
  input  wire logic       clock_i,                 // System clock, 125 MHz
  input  wire logic       rst_i,                   // Synchronous reset, high
  input  wire logic       clk_en_i,                // System clock enable
  input  wire logic       clock_mode_i,            // Clock-mode pin, low = external
  input  wire acsp_conv_s conv_i,                  // New conversion word
  input  wire logic       long_word_i,             // Output word is 24 bits
  input  wire logic       calib_sel_i,             // Select-high reads calibration
  input  wire logic       link_sclk_i,             // Host serial clock
  input  wire logic       read_frame_strobe_n_i,   // Read strobe, low active
  input  wire logic       write_frame_strobe_n_i,  // Write strobe, low active
  input  wire logic       register_select_i,       // Register select
  input  wire logic       serial_data_line_i,      // Serial data in
  output logic            serial_data_line_o,      // Serial data out
  output logic            serial_data_line_oe_o,   // Serial data drive enable
  output logic            word_ready_n_o,          // Word ready, low active
  output acsp_word_t      ctrl_reg_o,              // Control register
  output acsp_word_t      calib_reg_o              // Calibration register
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  acsp_rdy_e  rdy_state_r;
  acsp_word_t out_word_r;
  acsp_word_t ctrl_r;
  acsp_word_t calib_r;
  logic       len_long_r;
  logic       calib_rd_r;
  logic       mode_r;
  logic       strap_done_r;
  logic       seen_tgl_r;
  logic       ack_tgl_r;
  logic       wr_seen_r;
  logic       rfs_n_s;
  logic       rd_mid_s;
  logic       rd_tgl_s;
  logic       wr_tgl_s;
  logic       mode_s;
  logic       lnk_rst;
  logic       busy;
  logic       done_evt;
  logic       wr_evt;
  logic [4:0] rd_cnt_r;
  logic       rd_mid_r;
  logic       rd_tgl_r;
  logic       rd_kind_out_r;
  logic [4:0] wr_cnt_r;
  acsp_word_t wr_sh_r;
  acsp_word_t wr_word_r;
  logic       wr_sel_r;
  logic       wr_tgl_r;
  logic       out_rd;
  logic [4:0] rd_len;
  acsp_word_t rd_src;
  logic       rd_ok;

  // Index of the bit shown for a given position and word length
  function automatic logic [4:0] bit_index(input logic [4:0] len, input logic [4:0] pos);
    bit_index = len - pos - 5'h01;
  endfunction

  // ----------------------------------------
  // Crossings into the system domain
  // ----------------------------------------
  acsp_sync u_sync_rfs  (.clk_i(clock_i), .d_i(read_frame_strobe_n_i), .q_o(rfs_n_s));
  acsp_sync u_sync_mid  (.clk_i(clock_i), .d_i(rd_mid_r),              .q_o(rd_mid_s));
  acsp_sync u_sync_rd   (.clk_i(clock_i), .d_i(rd_tgl_r),              .q_o(rd_tgl_s));
  acsp_sync u_sync_wr   (.clk_i(clock_i), .d_i(wr_tgl_r),              .q_o(wr_tgl_s));
  acsp_sync u_sync_mode (.clk_i(clock_i), .d_i(clock_mode_i),          .q_o(mode_s));

  // Reset brought onto the link clock
  acsp_sync u_sync_rst  (.clk_i(link_sclk_i), .d_i(rst_i), .q_o(lnk_rst));

  // ----------------------------------------
  // System domain
  // ----------------------------------------

  // Any read strobe low, or an output read paused mid-word
  assign busy     = ~rfs_n_s | rd_mid_s;
  assign done_evt = (rd_tgl_s != seen_tgl_r);
  assign wr_evt   = (wr_tgl_s != wr_seen_r);

  // Clock-mode strap caught once after reset release
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_r       <= 1'b1;
      strap_done_r <= 1'b0;
    end else if (clk_en_i && !strap_done_r) begin
      mode_r       <= mode_s;
      strap_done_r <= 1'b1;
    end
  end

  // Ready flag and output word
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdy_state_r <= ACSP_NO_WORD;
      out_word_r  <= `ACSP_OUT_RST;
    end else if (clk_en_i) begin
      if (done_evt && rd_kind_out_r) begin
        rdy_state_r <= ACSP_NO_WORD;
      end else if (conv_i.valid && !busy) begin
        rdy_state_r <= ACSP_WORD_PEND;
        out_word_r  <= conv_i.data;
      end
      // Words arriving while busy are dropped
    end
  end

  // Completion handshake: seen at once, acknowledged after strobe lifts
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seen_tgl_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
    end else if (clk_en_i) begin
      seen_tgl_r <= rd_tgl_s;
      if (rfs_n_s && !done_evt) begin
        ack_tgl_r <= seen_tgl_r;
      end
    end
  end

  // Read options held steady while the read strobe is low or an output read is paused mid-word
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      len_long_r <= 1'b1;
      calib_rd_r <= 1'b0;
    end else if (clk_en_i && !busy) begin
      len_long_r <= long_word_i;
      calib_rd_r <= calib_sel_i;
    end
  end

  // Register loads from completed writes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_r    <= `ACSP_CTRL_RST;
      calib_r   <= `ACSP_CALIB_RST;
      wr_seen_r <= 1'b0;
    end else if (clk_en_i) begin
      wr_seen_r <= wr_tgl_s;
      if (wr_evt) begin
        if (wr_sel_r) begin
          calib_r <= wr_word_r;
        end else begin
          ctrl_r  <= wr_word_r;
        end
      end
    end
  end

  assign word_ready_n_o = (rdy_state_r == ACSP_NO_WORD);
  assign ctrl_reg_o     = ctrl_r;
  assign calib_reg_o    = calib_r;

  // ----------------------------------------
  // Link domain, read side
  // ----------------------------------------

  // Source and length chosen by the select line
  assign out_rd = register_select_i & ~calib_rd_r;
  assign rd_len = out_rd ? (len_long_r ? `ACSP_LEN_LONG : `ACSP_LEN_SHORT) : `ACSP_LEN_CTRL;
  assign rd_src = register_select_i ? (calib_rd_r ? calib_r : out_word_r) : ctrl_r;

  // Output reads need a pending word; no drive until the last read is retired
  assign rd_ok = ~mode_r & (~out_rd | ~word_ready_n_o) & (rd_tgl_r == ack_tgl_r);

  // Bit position steps on falling clock edges
  always_ff @(negedge link_sclk_i) begin
    if (lnk_rst) begin
      rd_cnt_r      <= `ACSP_CNT_RST;
      rd_mid_r      <= 1'b0;
      rd_tgl_r      <= 1'b0;
      rd_kind_out_r <= 1'b0;
    end else if (!read_frame_strobe_n_i && rd_ok) begin
      if (rd_cnt_r == rd_len - 5'h01) begin
        rd_cnt_r      <= `ACSP_CNT_RST;
        rd_mid_r      <= 1'b0;
        rd_tgl_r      <= ~rd_tgl_r;
        rd_kind_out_r <= out_rd;
      end else begin
        rd_cnt_r <= rd_cnt_r + 5'h01;
        rd_mid_r <= out_rd;
      end
    end
  end

  // Data shown from the held position; strobe high turns drive off
  assign serial_data_line_o    = rd_src[bit_index(rd_len, rd_cnt_r)];
  assign serial_data_line_oe_o = ~read_frame_strobe_n_i & rd_ok;

  // ----------------------------------------
  // Link domain, write side
  // ----------------------------------------

  // Bits taken on rising clock edges, MSB first
  always_ff @(posedge link_sclk_i) begin
    if (lnk_rst) begin
      wr_cnt_r  <= `ACSP_CNT_RST;
      wr_sh_r   <= `ACSP_CTRL_RST;
      wr_word_r <= `ACSP_CTRL_RST;
      wr_sel_r  <= 1'b0;
      wr_tgl_r  <= 1'b0;
    end else if (!write_frame_strobe_n_i && !mode_r) begin
      wr_sh_r <= {wr_sh_r[22:0], serial_data_line_i};
      if (wr_cnt_r == `ACSP_LEN_CTRL - 5'h01) begin
        wr_cnt_r  <= `ACSP_CNT_RST;
        wr_word_r <= {wr_sh_r[22:0], serial_data_line_i};
        wr_sel_r  <= register_select_i;
        wr_tgl_r  <= ~wr_tgl_r;
      end else begin
        wr_cnt_r <= wr_cnt_r + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_out_done;
    clk_en_i && done_evt && rd_kind_out_r;
  endsequence

  sequence s_flag_up;
    word_ready_n_o;
  endsequence

  a_ctrl_read_data: assert property (
    @(posedge link_sclk_i) disable iff (lnk_rst)
    (serial_data_line_oe_o && !register_select_i) |-> serial_data_line_o == ctrl_r[bit_index(rd_len, rd_cnt_r)])
    else $error("control read shows wrong bit");

  a_new_word_flag: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (clk_en_i && conv_i.valid && !busy && !(done_evt && rd_kind_out_r))
      |=> (!word_ready_n_o && out_word_r == $past(conv_i.data)))
    else $error("new word not flagged");

  a_done_flag_up: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_out_done |=> s_flag_up)
    else $error("ready flag did not rise after last bit");

  a_busy_discard: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (clk_en_i && busy && !done_evt) |=> $stable(out_word_r) && $stable(word_ready_n_o))
    else $error("word replaced during read");

  a_write_no_flag: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (wr_evt && !done_evt && !conv_i.valid) |=> $stable(word_ready_n_o))
    else $error("write changed ready flag");

  a_idle_no_xfer: assert property (
    @(posedge link_sclk_i) disable iff (lnk_rst)
    (out_rd && word_ready_n_o) |-> !serial_data_line_oe_o)
    else $error("output read driven with flag high");

  a_strobe_off_tri: assert property (
    @(posedge link_sclk_i) disable iff (lnk_rst)
    (read_frame_strobe_n_i && $past(read_frame_strobe_n_i)) |-> (!serial_data_line_oe_o && $stable(rd_cnt_r)))
    else $error("data driven or position lost with strobe high");

  a_word_wrap: assert property (
    @(negedge link_sclk_i) disable iff (lnk_rst)
    (!read_frame_strobe_n_i && rd_ok && rd_cnt_r == rd_len - 5'h01) |=> rd_cnt_r == `ACSP_CNT_RST)
    else $error("bit position not returned to MSB");

  a_ctrl_load: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (clk_en_i && wr_evt && !wr_sel_r) |=> ctrl_r == $past(wr_word_r))
    else $error("control register not loaded");

  a_mode_blocks: assert property (
    @(posedge link_sclk_i) disable iff (lnk_rst)
    mode_r |-> !serial_data_line_oe_o)
    else $error("port active with clock mode high");

endmodule

/* File: acsp_host_model.sv */
// Behavioural host that clocks the serial port from outside
`timescale 1ns/1ps
module acsp_host_model (
  output logic      sclk_o,   // Serial clock, parked low between pulses
  output logic      rfs_n_o,  // Read strobe, low active
  output logic      tfs_n_o,  // Write strobe, low active
  output logic      sel_o,    // Register select
  output logic      sdo_o,    // Write data onto the line
  input  wire logic sdi_i,    // Resolved data line
  input  wire logic oe_i,     // Device drive enable
  input  wire logic rdy_n_i   // Word ready flag
);
  logic p_oe;   // Drive enable seen in a pause
  logic p_rdy;  // Ready flag seen in a pause

  // Idle levels, clock parked low
  initial begin
    sclk_o = 1'b0;
    rfs_n_o = 1'b1;
    tfs_n_o = 1'b1;
    sel_o = 1'b0;
    sdo_o = 1'b0;
  end

  // Bare clock pulses with both strobes high
  task automatic pulse_clk(input int n);
    repeat (n) begin
      #15 sclk_o <= 1'b1;
      #15 sclk_o <= 1'b0;
    end
  endtask

  // Read n bits, MSB first, pausing before bit p
  task automatic rd(input logic s, input int n, input int p, output logic [23:0] w);
    w = 24'h000000;
    sel_o <= s;
    #15 rfs_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == p) begin
        // Lift strobe a little after the falling edge, so that edge still counts
        #5 rfs_n_o <= 1'b1;
        #5 p_oe = oe_i;
        p_rdy = rdy_n_i;
        #20 rfs_n_o <= 1'b0;
      end
      #15 w[n-1-i] = sdi_i;
      sclk_o <= 1'b1;
      #15 sclk_o <= 1'b0;
    end
    #15 rfs_n_o <= 1'b1;
  endtask

  // Write 24 bits, MSB first, pausing before bit p
  task automatic wr(input logic s, input logic [23:0] w, input int p);
    sel_o <= s;
    #15 tfs_n_o <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (i == p) begin
        tfs_n_o <= 1'b1;
        #30 tfs_n_o <= 1'b0;
      end
      sdo_o <= w[23-i];
      #15 sclk_o <= 1'b1;
      #15 sclk_o <= 1'b0;
    end
    #15 tfs_n_o <= 1'b1;
    sdo_o <= ~sdo_o;
  endtask

  // Strobe low without clocking, report drive enable
  task automatic probe(output logic o);
    sel_o <= 1'b1;
    #15 rfs_n_o <= 1'b0;
    #30 o = oe_i;
    rfs_n_o <= 1'b1;
  endtask
endmodule

/* File: acsp_port_tb_top.sv */
// Self-checking bench for the external-clock serial port
`timescale 1ns/1ps
module acsp_port_tb_top;
  import acsp_pkg::*;
  logic       clock_i, rst_i, clk_en_i, clock_mode_i, long_word_i, calib_sel_i;
  acsp_conv_s conv_i;
  logic       sclk, rfs_n, tfs_n, sel, sdo, dout, oe, rdy_n, line, o;
  acsp_word_t ctrl, calib, got;
  int         n_errors = 0;
  int         checked = 0;

  // Data line resolved from both drivers
  assign line = oe ? dout : sdo;

  acsp_port uut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .clock_mode_i(clock_mode_i),
    .conv_i(conv_i), .long_word_i(long_word_i), .calib_sel_i(calib_sel_i), .link_sclk_i(sclk),
    .read_frame_strobe_n_i(rfs_n), .write_frame_strobe_n_i(tfs_n), .register_select_i(sel),
    .serial_data_line_i(line), .serial_data_line_o(dout), .serial_data_line_oe_o(oe),
    .word_ready_n_o(rdy_n), .ctrl_reg_o(ctrl), .calib_reg_o(calib));
  acsp_host_model host (.sclk_o(sclk), .rfs_n_o(rfs_n), .tfs_n_o(tfs_n), .sel_o(sel), .sdo_o(sdo),
    .sdi_i(line), .oe_i(oe), .rdy_n_i(rdy_n));

  // System clock
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk_word(input acsp_word_t g, input acsp_word_t e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic idle();
    repeat (12) @(posedge clock_i);
    #1;
  endtask
  task automatic put_word(input acsp_word_t d);
    @(posedge clock_i);
    conv_i <= '{valid: 1'b1, data: d};
    @(posedge clock_i);
    conv_i <= '{valid: 1'b0, data: d};
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic finish_test();
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ctrl();
    host.wr(1'b0, 24'hA5C3E1, 99);
    idle();
    chk_word(ctrl, 24'hA5C3E1);
    chk_bit(rdy_n, 1'b1);
    host.rd(1'b0, 24, 99, got);
    idle();
    chk_word(got, 24'hA5C3E1);
    chk_bit(rdy_n, 1'b1);
    $display("test ctrl done");
  endtask
  task automatic t_calib();
    host.wr(1'b1, 24'h3C5A96, 9);
    idle();
    chk_word(calib, 24'h3C5A96);
    chk_word(ctrl, 24'hA5C3E1);
    calib_sel_i <= 1'b1;
    idle();
    host.rd(1'b1, 24, 13, got);
    idle();
    chk_word(got, 24'h3C5A96);
    chk_bit(host.p_oe, 1'b0);
    calib_sel_i <= 1'b0;
    $display("test calib done");
  endtask
  task automatic t_out24();
    long_word_i <= 1'b1;
    put_word(24'h112233);
    chk_bit(rdy_n, 1'b0);
    put_word(24'hC0FFEE);
    host.rd(1'b0, 24, 99, got);
    idle();
    chk_bit(rdy_n, 1'b0);
    host.rd(1'b1, 24, 10, got);
    idle();
    chk_word(got, 24'hC0FFEE);
    chk_bit(host.p_oe, 1'b0);
    chk_bit(host.p_rdy, 1'b0);
    chk_bit(rdy_n, 1'b1);
    $display("test out24 done");
  endtask
  task automatic t_out16();
    long_word_i <= 1'b0;
    put_word(24'h89ABCD);
    fork
      host.rd(1'b1, 16, 99, got);
      begin
        #200;
        put_word(24'h445566);
      end
    join
    idle();
    chk_word(got, 24'h00ABCD);
    chk_bit(rdy_n, 1'b1);
    $display("test out16 done");
  endtask
  task automatic t_norun();
    host.probe(o);
    idle();
    chk_bit(o, 1'b0);
    chk_bit(rdy_n, 1'b1);
    $display("test norun done");
  endtask

  // Watchdog
  initial begin
    #100000;
    n_errors++;
    $display("timeout");
    finish_test();
  end

  // Main sequence
  initial begin
    rst_i <= 1'b1;
    clk_en_i <= 1'b1;
    clock_mode_i <= 1'b0;
    long_word_i <= 1'b1;
    calib_sel_i <= 1'b0;
    conv_i <= '{valid: 1'b0, data: 24'h000000};
    fork
      host.pulse_clk(3);
      repeat (12) @(posedge clock_i);
    join
    rst_i <= 1'b0;
    host.pulse_clk(3);
    idle();
    t_ctrl();
    t_calib();
    t_out24();
    t_out16();
    t_norun();
    finish_test();
  end
endmodule
